// *** hdl/gpp_port.sv ***
// General-purpose ports 2 and 3 with reset pin sharing and pin interrupts
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "gpp_consts.svh"

module gpp_port (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Port 2 pins
  input  wire logic [7:0]            port2_pin_in,
  output gpp_pkg::gpp_pin_out_t      port2_pin_out,
  output logic                       port2_bit2_pin_pd,
  output logic                       port2_bit3_pin_pd,
  // Port 3 pins
  input  wire logic [7:0]            port3_pin_in,
  output gpp_pkg::gpp_pin_out_t      port3_pin_out,
  output logic                       port3_bit4_pin_pu,
  // Option setting and chip reset
  input  wire logic                  option_port_mode,
  output logic                       core_reset_n,
  // Interrupt
  output logic                       irq
);

  // Port state, index 0 is port 2, index 1 is port 3
  logic [1:0][7:0]          out_q;
  logic [1:0][7:0]          dir_q;
  logic [1:0][7:0]          drv_prev_q;
  logic [1:0][7:0]          sync1_q;
  logic [1:0][7:0]          pin_s_q;
  logic [1:0]               stat_q;
  logic [1:0]               stat_d;
  logic [1:0]               mask_q;
  logic [1:0]               mask_d;
  logic [1:0]               pin_evt;
  logic                     irq_q;
  // Bus state
  logic [7:0]               aw_addr_q;
  logic                     aw_full_q;
  logic                     awready_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;
  logic                     w_full_q;
  logic                     wready_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     arready_q;
  logic                     rvalid_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic                     do_wr;
  logic                     wr_lane0;
  logic                     wr_hit;
  logic [31:0]              rd_word;
  logic                     rd_hit;
  // Reset sequencer
  gpp_pkg::gpp_rst_st_t     rst_st_q;
  logic [2:0]               opt_cnt_q;
  logic                     option_q;
  logic                     core_rst_n_q;
  logic                     port_rst;
  logic                     pd_q;
  logic                     pu_q;
  logic                     rst_pin_s;
  // Single-bit operation
  gpp_pkg::gpp_bitop_t      bitop;
  logic [7:0]               bitop_rd;
  logic [7:0]               bitop_new;

  // Two-stage synchroniser on every port pin, one process for the whole vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 16'h0000;
      pin_s_q <= 16'h0000;
    end else begin
      sync1_q <= {port3_pin_in, port2_pin_in};
      pin_s_q <= sync1_q;
    end
  end

  assign rst_pin_s = pin_s_q[1][`GPP_B_P3_RST];

  // Reset sequencer: option read after release, shared pin as reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_st_q     <= gpp_pkg::gpp_st_opt;
      opt_cnt_q    <= 3'h0;
      option_q     <= 1'b0;
      core_rst_n_q <= 1'b0;
    end else begin
      case (rst_st_q)
        gpp_pkg::gpp_st_opt: begin
          if (!rst_pin_s) begin
            opt_cnt_q <= 3'h0;
          end else if (opt_cnt_q == `GPP_OPT_CYC - 3'h1) begin
            option_q     <= option_port_mode;
            core_rst_n_q <= 1'b1;
            rst_st_q     <= gpp_pkg::gpp_st_run;
            opt_cnt_q    <= 3'h0;
          end else begin
            opt_cnt_q <= opt_cnt_q + 3'h1;
          end
        end
        gpp_pkg::gpp_st_run: begin
          if (!option_q && !rst_pin_s) begin
            core_rst_n_q <= 1'b0;
            rst_st_q     <= gpp_pkg::gpp_st_pinrst;
          end
        end
        gpp_pkg::gpp_st_pinrst: begin
          if (rst_pin_s) begin
            rst_st_q <= gpp_pkg::gpp_st_opt;
          end
        end
        default: begin
          rst_st_q     <= gpp_pkg::gpp_st_opt;
          core_rst_n_q <= 1'b0;
        end
      endcase
    end
  end

  assign port_rst = !aresetn || !core_rst_n_q;

  // Weak pulls held while the chip is in reset
  always_ff @(posedge aclk) begin
    pd_q <= port_rst;
    pu_q <= port_rst;
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (s_axi_awvalid && awready_q) begin
      aw_addr_q <= s_axi_awaddr;
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (s_axi_wvalid && wready_q) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // Write decode, one pulse per write
  always_comb begin
    do_wr    = aw_full_q && w_full_q && !bvalid_q;
    wr_lane0 = do_wr && w_strb_q[0];
    case (aw_addr_q)
      `GPP_A_OUT2, `GPP_A_DIR2, `GPP_A_OUT3, `GPP_A_DIR3,
      `GPP_A_IN2, `GPP_A_IN3, `GPP_A_STAT, `GPP_A_MASK,
      `GPP_A_BITOP, `GPP_A_BOOT: wr_hit = 1'b1;
      default:                   wr_hit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `GPP_RESP_OK;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `GPP_RESP_OK : `GPP_RESP_ERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Single-bit operation: whole port read, one bit changed
  always_comb begin
    bitop     = gpp_pkg::gpp_bitop_t'(w_data_q[4:0]);
    bitop_rd  = (dir_q[bitop.port_sel] & out_q[bitop.port_sel])
              | (~dir_q[bitop.port_sel] & pin_s_q[bitop.port_sel]);
    bitop_new = bitop_rd;
    bitop_new[bitop.bit_idx] = bitop.value;
  end

  // Output latches and direction registers
  always_ff @(posedge aclk) begin
    if (port_rst) begin
      out_q <= {`GPP_OUT_RST, `GPP_OUT_RST};
      dir_q <= {`GPP_DIR_RST, `GPP_DIR_RST};
    end else if (wr_lane0) begin
      case (aw_addr_q)
        `GPP_A_OUT2:  out_q[0] <= w_data_q[7:0];
        `GPP_A_DIR2:  dir_q[0] <= w_data_q[7:0];
        `GPP_A_OUT3:  out_q[1] <= w_data_q[7:0];
        `GPP_A_DIR3:  dir_q[1] <= w_data_q[7:0] & `GPP_P3_DIR_MASK;
        `GPP_A_BITOP: out_q[bitop.port_sel] <= bitop_new;
        default:      out_q <= out_q;
      endcase
    end
  end

  // Previous driven level for change detection
  always_ff @(posedge aclk) begin
    if (port_rst) begin
      drv_prev_q <= {`GPP_OUT_RST, `GPP_OUT_RST};
    end else begin
      drv_prev_q <= out_q;
    end
  end

  // Output level change on interrupt-capable pins
  assign pin_evt[0] = dir_q[0][`GPP_B_P2_IRQ]
                    && (out_q[0][`GPP_B_P2_IRQ] != drv_prev_q[0][`GPP_B_P2_IRQ]);
  assign pin_evt[1] = dir_q[1][`GPP_B_P3_IRQ]
                    && (out_q[1][`GPP_B_P3_IRQ] != drv_prev_q[1][`GPP_B_P3_IRQ]);

  // Status write-one-to-clear, set wins; mask update
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_lane0 && aw_addr_q == `GPP_A_STAT) begin
      stat_d = stat_q & ~w_data_q[1:0];
    end
    if (wr_lane0 && aw_addr_q == `GPP_A_MASK) begin
      mask_d = w_data_q[1:0];
    end
    stat_d = stat_d | pin_evt;
  end

  // Interrupt status and mask
  always_ff @(posedge aclk) begin
    if (port_rst) begin
      stat_q <= `GPP_STAT_RST;
      mask_q <= `GPP_MASK_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & ~mask_d);
    end
  end

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `GPP_A_OUT2:  rd_word[7:0] = out_q[0];
      `GPP_A_DIR2:  rd_word[7:0] = dir_q[0];
      `GPP_A_OUT3:  rd_word[7:0] = out_q[1];
      `GPP_A_DIR3:  rd_word[7:0] = dir_q[1];
      `GPP_A_IN2:   rd_word[7:0] = pin_s_q[0];
      `GPP_A_IN3:   rd_word[7:0] = pin_s_q[1];
      `GPP_A_STAT:  rd_word[1:0] = stat_q;
      `GPP_A_MASK:  rd_word[1:0] = mask_q;
      `GPP_A_BITOP: rd_word[0]   = 1'b0;
      `GPP_A_BOOT:  rd_word[1:0] = {core_rst_n_q, option_q};
      default:      rd_hit       = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `GPP_RESP_OK;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? `GPP_RESP_OK : `GPP_RESP_ERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Bus outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  // Pin outputs: output-mode bits drive their latch
  assign port2_pin_out.drv = out_q[0];
  assign port2_pin_out.oe  = dir_q[0];
  assign port3_pin_out.drv = out_q[1];
  assign port3_pin_out.oe  = dir_q[1];
  // Pulls, chip reset and interrupt
  assign port2_bit2_pin_pd = pd_q;
  assign port2_bit3_pin_pd = pd_q;
  assign port3_bit4_pin_pu = pu_q;
  assign core_reset_n      = core_rst_n_q;
  assign irq               = irq_q;

endmodule

// *** include/gpp_consts.svh ***
// Constants for the general-purpose port block: map, fields, resets, timing
//
// Contract
// - During reset, port 2 bits 2 and 3 are weakly pulled to ground.
// - During reset, the shared reset / port 3 bit 4 pin is pulled high.
// - With the option set to port use, the shared pin never resets.
// - Option read after reset release; low shared pin beforehand keeps reset.
// - Output level change on either interrupt-capable pin sets its request flag.
// - Single-bit port operation reads and rewrites the whole 8-bit port.
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

// Register byte addresses
`define GPP_A_OUT2    8'h00
`define GPP_A_DIR2    8'h04
`define GPP_A_OUT3    8'h08
`define GPP_A_DIR3    8'h0C
`define GPP_A_IN2     8'h10
`define GPP_A_IN3     8'h14
`define GPP_A_STAT    8'h18
`define GPP_A_MASK    8'h1C
`define GPP_A_BITOP   8'h20
`define GPP_A_BOOT    8'h24

// Reset values
`define GPP_OUT_RST   8'h00
`define GPP_DIR_RST   8'h00
`define GPP_STAT_RST  2'h0
`define GPP_MASK_RST  2'h3

// Port 3 bit 4 is input only: direction write mask
`define GPP_P3_DIR_MASK 8'hEF

// Pin bit positions
`define GPP_B_P2_PD_LO 2
`define GPP_B_P2_PD_HI 3
`define GPP_B_P2_IRQ   1
`define GPP_B_P3_IRQ   2
`define GPP_B_P3_RST   4

// Cycles the option setting takes to be read after release
`define GPP_OPT_CYC   3'h4

// AXI responses
`define GPP_RESP_OK   2'h0
`define GPP_RESP_ERR  2'h2

`endif

// *** include/gpp_pkg.sv ***
// Types shared by the general-purpose port block
package gpp_pkg;

  // Pin drive of one 8-bit port
  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] oe;
  } gpp_pin_out_t;

  // Single-bit port operation as written by software
  typedef struct packed {
    logic       port_sel;
    logic       value;
    logic [2:0] bit_idx;
  } gpp_bitop_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    gpp_st_opt    = 2'b00,
    gpp_st_run    = 2'b01,
    gpp_st_pinrst = 2'b10
  } gpp_rst_st_t;

endpackage

// *** bench/gpp_board.sv ***
// Board model: drives, pulls and floating levels at the port pins
`timescale 1ns/1ps
module gpp_board (
  // Clock
  input wire logic                  aclk,
  // Device drive and pulls
  input wire gpp_pkg::gpp_pin_out_t port2_pin_out,
  input wire gpp_pkg::gpp_pin_out_t port3_pin_out,
  input wire logic                  port2_bit2_pin_pd,
  input wire logic                  port2_bit3_pin_pd,
  input wire logic                  port3_bit4_pin_pu,
  // Board levels and floating bits
  input wire logic [7:0]            ext2,
  input wire logic [7:0]            ext3,
  input wire logic [7:0]            flt2,
  input wire logic [7:0]            flt3,
  // Pin levels
  output logic [7:0]                port2_pin_in,
  output logic [7:0]                port3_pin_in
);
  logic [7:0] last2_q, last3_q, pull2, pull3;
  // Pulls only show on floating pins
  always_comb begin
    pull2 = {4'h0, port2_bit3_pin_pd, port2_bit2_pin_pd, 2'h0};
    pull3 = {3'h0, port3_bit4_pin_pu, 4'h0};
    for (int i = 0; i < 8; i++) begin
      port2_pin_in[i] = port2_pin_out.oe[i] ? port2_pin_out.drv[i] :
        !flt2[i] ? ext2[i] : pull2[i] ? 1'b0 : ~last2_q[i];
      port3_pin_in[i] = port3_pin_out.oe[i] ? port3_pin_out.drv[i] :
        !flt3[i] ? ext3[i] : pull3[i] ? 1'b1 : ~last3_q[i];
    end
  end
  // Unpulled floating pins flip each cycle
  always_ff @(posedge aclk) begin
    last2_q <= port2_pin_in;
    last3_q <= port3_pin_in;
  end
endmodule

// *** bench/gpp_port_asserts.sv ***
// Concurrent checks on the port block
`timescale 1ns/1ps
module gpp_port_asserts (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Read handshake and write response
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_bvalid,
  // Pins
  input wire logic [7:0]            port3_pin_in,
  input wire gpp_pkg::gpp_pin_out_t port2_pin_out,
  input wire gpp_pkg::gpp_pin_out_t port3_pin_out,
  input wire logic                  port2_bit2_pin_pd,
  input wire logic                  port2_bit3_pin_pd,
  input wire logic                  port3_bit4_pin_pu,
  // Reset control and interrupt
  input wire logic                  option_port_mode,
  input wire logic                  core_reset_n,
  input wire logic                  irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset pin held low, and a finished write
  sequence s_pin_low3;
    !port3_pin_in[4] [*3];
  endsequence
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  // Pulls follow the core reset
  AST_PD_RST: assert property (!core_reset_n |=> port2_bit2_pin_pd && port2_bit3_pin_pd)
    else $error("pull-down off in reset");
  AST_PU_RST: assert property (!core_reset_n |=> port3_bit4_pin_pu)
    else $error("pull-up off in reset");
  AST_PULL_OFF: assert property (core_reset_n && $past(core_reset_n)
    |-> !port2_bit3_pin_pd && !port3_bit4_pin_pu)
    else $error("pull left on in run");
  // Shared pin reset behaviour
  AST_OPT_PORT: assert property (core_reset_n && option_port_mode |=> core_reset_n)
    else $error("reset from port pin");
  AST_PIN_RST: assert property (!option_port_mode ##0 s_pin_low3 |=> !core_reset_n)
    else $error("low reset pin ignored");
  AST_RST_HOLD: assert property ($rose(core_reset_n) && !option_port_mode
    |-> $past(port3_pin_in[4], 3) && $past(port3_pin_in[4], 4))
    else $error("reset left with pin low");
  // Outputs change only through writes; no irq in core reset; read answered next cycle
  AST_DRV_WR: assert property (core_reset_n && $past(core_reset_n) &&
    ($changed(port2_pin_out) || $changed(port3_pin_out)) |-> s_wr_done)
    else $error("pin drive changed without write");
  AST_IRQ_CORE: assert property (!core_reset_n [*2] |-> !irq)
    else $error("irq in core reset");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind gpp_port gpp_port_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .port3_pin_in, .port2_pin_out, .port3_pin_out,
  .port2_bit2_pin_pd, .port2_bit3_pin_pd, .port3_bit4_pin_pu, .option_port_mode,
  .core_reset_n, .irq);

// *** bench/gpp_port_bench.sv ***
// Self-checking bench for the port block
`timescale 1ns/1ps
`include "gpp_consts.svh"
module gpp_port_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
    logic [1:0]  r;
  } gpp_row_t;
  logic                  aclk, aresetn, option_port_mode, core_reset_n, irq;
  logic [7:0]            s_axi_awaddr, s_axi_araddr, port2_pin_in, port3_pin_in;
  logic [7:0]            ext2, ext3, flt2, flt3;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic                  port2_bit2_pin_pd, port2_bit3_pin_pd, port3_bit4_pin_pu;
  gpp_pkg::gpp_pin_out_t port2_pin_out, port3_pin_out;
  int                    errors, checks_done;
  gpp_row_t              rows [7] = '{
    '{`GPP_A_OUT2, 32'h0000_00A5, 32'h0000_00A5, `GPP_RESP_OK},
    '{`GPP_A_DIR2, 32'h0000_000F, 32'h0000_000F, `GPP_RESP_OK},
    '{`GPP_A_DIR3, 32'h0000_00FF, 32'h0000_00EF, `GPP_RESP_OK},
    '{`GPP_A_MASK, 32'h0000_0001, 32'h0000_0001, `GPP_RESP_OK},
    '{`GPP_A_IN3, 32'h0000_00FF, 32'h0000_0010, `GPP_RESP_OK},
    '{`GPP_A_BOOT, 32'h0000_00FF, 32'h0000_0002, `GPP_RESP_OK},
    '{8'h40, 32'h0000_00FF, 32'h0000_0000, `GPP_RESP_ERR}};
  gpp_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port2_pin_in, .port2_pin_out,
    .port2_bit2_pin_pd, .port2_bit3_pin_pd, .port3_pin_in, .port3_pin_out,
    .port3_bit4_pin_pu, .option_port_mode, .core_reset_n, .irq);
  gpp_board u_board (.aclk, .port2_pin_out, .port3_pin_out, .port2_bit2_pin_pd,
    .port2_bit3_pin_pd, .port3_bit4_pin_pu, .ext2, .ext3, .flt2, .flt3, .port2_pin_in,
    .port3_pin_in);
  // Clock
  always #10 aclk = ~aclk;
  // Compare and count
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write: address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  // Bus read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rs);
    chk({rs, rd}, {`GPP_RESP_OK, e});
  endtask
  // Reset for 5 cycles, pulls checked while held
  task automatic do_rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk({port2_bit2_pin_pd, port2_bit3_pin_pd, port3_bit4_pin_pu}, 3'b111);
    chk(port2_pin_in[3:2], 2'b00);
    aresetn <= 1'b1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    test_done();
  end
  initial begin
    {aclk, aresetn, option_port_mode, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {errors, checks_done, ext2, flt3} = '0;
    s_axi_wstrb = 4'hF;
    ext3 = 8'h10;
    flt2 = 8'h0C;
    @(posedge aclk);
    do_rst();
    repeat (12) @(posedge aclk);
    chk({core_reset_n, port2_bit2_pin_pd, port3_bit4_pin_pu}, 3'b100);
    // Register table rows
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, rs);
      chk(rs, rows[i].r);
      axr(rows[i].a, rd, rs);
      chk({rs, rd}, {rows[i].r, rows[i].e});
    end
    chk(port2_pin_out, 16'hA50F);
    // Pin events masked, then the port 2 event unmasked and cleared
    axw(`GPP_A_MASK, 32'h0000_0003, rs);
    axw(`GPP_A_OUT2, 32'h0000_00A7, rs);
    axw(`GPP_A_OUT3, 32'h0000_0004, rs);
    rdc(`GPP_A_STAT, 32'h0000_0003);
    chk(irq, 1'b0);
    axw(`GPP_A_MASK, 32'h0000_0002, rs);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    axw(`GPP_A_STAT, 32'h0000_0001, rs);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rdc(`GPP_A_STAT, 32'h0000_0002);
    // Single-bit operations on mixed ports
    ext2 <= 8'h50;
    repeat (3) @(posedge aclk);
    axw(`GPP_A_BITOP, 32'h0000_0000, rs);
    rdc(`GPP_A_OUT2, 32'h0000_0056);
    axw(`GPP_A_BITOP, 32'h0000_0018, rs);
    rdc(`GPP_A_OUT3, 32'h0000_0015);
    chk(port3_pin_out, 16'h15EF);
    // Shared pin as reset input
    ext3[4] <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({core_reset_n, port3_bit4_pin_pu, port2_pin_out}, 18'h1_0000);
    ext3[4] <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(core_reset_n, 1'b1);
    // Pin low across release keeps reset
    ext3[4] <= 1'b0;
    do_rst();
    repeat (20) @(posedge aclk);
    chk({core_reset_n, port2_bit3_pin_pd}, 2'b01);
    ext3[4] <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(core_reset_n, 1'b1);
    // Port mode: pin low never resets
    option_port_mode <= 1'b1;
    do_rst();
    repeat (12) @(posedge aclk);
    ext3[4] <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(core_reset_n, 1'b1);
    rdc(`GPP_A_BOOT, 32'h0000_0003);
    test_done();
  end
endmodule
